// *** hw/aslk_consts.vh ***
`ifndef ASLK_CONSTS_VH
`define ASLK_CONSTS_VH

// clock and line rate
`define ASLK_CLK_HZ        200000000
`define ASLK_BAUD          115200
`define ASLK_BIT_CYCLES    (`ASLK_CLK_HZ / `ASLK_BAUD)
`define ASLK_HALF_CYCLES   (`ASLK_BIT_CYCLES / 2)

// frame layout: start, eight data, stop
`define ASLK_DATA_BITS     8
`define ASLK_FRAME_BITS    10
`define ASLK_STOP_IDX      4'h9

// phase timing in milliseconds
`define ASLK_MEAS_MS       25
`define ASLK_CMD_TO_MS     100
`define ASLK_CYC_PER_MS    (`ASLK_CLK_HZ / 1000)
`define ASLK_MEAS_CYCLES   (`ASLK_MEAS_MS * `ASLK_CYC_PER_MS)
`define ASLK_CMD_TO_CYCLES (`ASLK_CMD_TO_MS * `ASLK_CYC_PER_MS)

// measurement-phase buffer depth and ascii terminators
`define ASLK_BUF_DEPTH     3'h4
`define ASLK_CHAR_CR       8'h0d
`define ASLK_CHAR_LF       8'h0a

`endif

// *** hw/aslk_link.v ***
// What this block does
// - 115200 baud, 8N1, no flow control
// - measurement phase buffers four characters only
// - measurement work lasts up to 25 ms
// - carriage return ends command, starts execution
// - loop: measure, check buffer, process, repeat
// - a command whose CR is buffered gets a status response; one whose CR is lost to the capture limit times out and gets none
// - every response ends with CR then LF
`timescale 1ns/1ps
`include "aslk_consts.vh"

module aslk_link #(
    parameter BIT_CYCLES  = `ASLK_BIT_CYCLES,
    parameter HALF_CYCLES = `ASLK_HALF_CYCLES,
    parameter MEAS_CYCLES = `ASLK_MEAS_CYCLES,
    parameter CMD_TO      = `ASLK_CMD_TO_CYCLES,
    parameter CW          = 11,
    parameter TW          = 25
) (
    // clock and reset
    input  wire       i_sys_clk,
    input  wire       i_rst_b,
    // serial line
    input  wire       i_rxd,
    output wire       o_txd,
    // command bytes toward the executor
    output reg  [7:0] o_cmd_data,
    output reg        o_cmd_valid,
    output reg        o_cmd_exec,
    output reg        o_cmd_abort,
    // response bytes from the executor
    input  wire [7:0] i_rsp_data,
    input  wire       i_rsp_valid,
    input  wire       i_rsp_last,
    output wire       o_rsp_ready,
    // phase status
    output reg        o_meas_phase
);

    ////////////////////////////////////////////////////////////////////////
    // constants; counts are cut to their counter widths on purpose
    localparam integer  BIT_M1    = BIT_CYCLES - 1, HALF_M1 = HALF_CYCLES - 1;
    localparam integer  MEAS_M1   = MEAS_CYCLES - 1, TO_M1 = CMD_TO - 1;
    localparam [CW-1:0] BIT_LAST  = BIT_M1[CW-1:0];
    localparam [CW-1:0] HALF_LAST = HALF_M1[CW-1:0];
    localparam [TW-1:0] MEAS_LAST = MEAS_M1[TW-1:0];
    localparam [TW-1:0] TO_LAST   = TO_M1[TW-1:0];
    localparam [3:0]    STOP_IDX  = `ASLK_STOP_IDX;
    localparam [2:0]    DEPTH     = `ASLK_BUF_DEPTH;
    localparam [7:0]    CHAR_CR   = `ASLK_CHAR_CR;
    localparam [7:0]    CHAR_LF   = `ASLK_CHAR_LF;
    // one-hot phase states
    localparam [5:0] S_MEAS  = 6'h01;  // conversion work, limited capture
    localparam [5:0] S_CHECK = 6'h02;  // look for a pending command
    localparam [5:0] S_CMD   = 6'h04;  // drain the line until CR
    localparam [5:0] S_RESP  = 6'h08;  // forward executor reply bytes
    localparam [5:0] S_TCR   = 6'h10;  // send terminating CR
    localparam [5:0] S_TLF   = 6'h20;  // send terminating LF
    // two-bit ring pointer step, shared by both pointers
    function [1:0] aslk_inc;
        input [1:0] p;
        begin
            aslk_inc = p + 2'h1;
        end
    endfunction
    ////////////////////////////////////////////////////////////////////////
    // receive path: three-flop synchroniser and filter
    reg          sync1;      // metastability stage, read only by sync2
    reg          sync2;      // second stage
    reg          sync3;      // third stage, compared against sync2
    reg          rx_lvl;     // filtered line level
    reg          rx_lvl_d;   // previous filtered level for edge detect
    reg          rx_busy;    // a frame is being sampled
    reg [3:0]    rx_idx;     // bit index within the frame
    reg [CW-1:0] rx_baud;    // cycles to next sample point
    reg [7:0]    rx_shift;   // data assembled lsb first
    reg          rx_vld;     // one-cycle pulse: byte received
    reg [7:0]    rx_byte;    // received byte
    // a change counts only once the last two stages agree
    always @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            sync1    <= 1'b1;
            sync2    <= 1'b1;
            sync3    <= 1'b1;
            rx_lvl   <= 1'b1;
            rx_lvl_d <= 1'b1;
        end else begin
            sync1    <= i_rxd;
            sync2    <= sync1;
            sync3    <= sync2;
            rx_lvl_d <= rx_lvl;
            if (sync2 == sync3) begin
                rx_lvl <= sync3;
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // frame sampler: mid-bit sampling, framing errors dropped silently
    always @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rx_busy  <= 1'b0;
            rx_idx   <= 4'h0;
            rx_baud  <= {CW{1'b0}};
            rx_shift <= 8'h00;
            rx_vld   <= 1'b0;
            rx_byte  <= 8'h00;
        end else begin
            rx_vld <= 1'b0;
            if (!rx_busy) begin
                // falling edge of the filtered line opens a frame
                if (rx_lvl_d && !rx_lvl) begin
                    rx_busy <= 1'b1;
                    rx_idx  <= 4'h0;
                    rx_baud <= HALF_LAST;
                end
            end else if (rx_baud != {CW{1'b0}}) begin
                rx_baud <= rx_baud - {{(CW-1){1'b0}}, 1'b1};
            end else begin
                rx_baud <= BIT_LAST;
                rx_idx  <= rx_idx + 4'h1;
                if (rx_idx == 4'h0) begin
                    // glitch rather than start bit: give up
                    if (rx_lvl) begin
                        rx_busy <= 1'b0;
                    end
                end else if (rx_idx == STOP_IDX) begin
                    // no parity; a low stop bit discards the byte
                    rx_busy <= 1'b0;
                    if (rx_lvl) begin
                        rx_vld  <= 1'b1;
                        rx_byte <= rx_shift;
                    end
                end else begin
                    rx_shift <= {rx_lvl, rx_shift[7:1]};
                end
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // command ring buffer and phase sequencer
    reg [7:0]    cbuf [0:3]; // command characters awaiting hand-off
    reg [1:0]    wr_ptr;     // next slot to fill
    reg [1:0]    rd_ptr;     // next slot to drain
    reg [2:0]    fill;       // characters held
    reg [5:0]    state;      // one-hot phase
    reg [TW-1:0] tmr;        // phase timer, counts down
    wire         tx_ready;   // transmitter idle
    reg          tx_valid;   // byte offered to transmitter
    reg [7:0]    tx_data;    // byte offered to transmitter
    reg          push;       // store the received byte this cycle
    reg          pop;        // hand one stored byte on this cycle
    reg [5:0]    next_state; // phase for the next cycle
    // capture limit: only four characters while measuring; the rest is lost
    always @* begin
        push = 1'b0;
        pop  = 1'b0;
        if (rx_vld && (state == S_MEAS) && (fill < DEPTH)) begin
            push = 1'b1;
        end else if (rx_vld && (state == S_CMD)) begin
            push = 1'b1;
        end
        if ((state == S_CMD) && (fill != 3'h0)) begin
            pop = 1'b1;
        end
    end

    // draining one per cycle outruns the line by far, so no overflow in S_CMD
    always @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            wr_ptr <= 2'h0;
            rd_ptr <= 2'h0;
            fill   <= 3'h0;
        end else if (state == S_RESP) begin
            // leftovers after CR are not part of any command
            wr_ptr <= 2'h0;
            rd_ptr <= 2'h0;
            fill   <= 3'h0;
        end else begin
            if (push) begin
                wr_ptr <= aslk_inc(wr_ptr);
            end
            if (pop) begin
                rd_ptr <= aslk_inc(rd_ptr);
            end
            if (push && !pop) begin
                fill <= fill + 3'h1;
            end else if (pop && !push) begin
                fill <= fill - 3'h1;
            end
        end
    end

    // storage itself has no reset; fill tells which slots mean anything
    always @(posedge i_sys_clk) begin
        if (push) begin
            cbuf[wr_ptr] <= rx_byte;
        end
    end
    // next phase of the measure / check / process loop
    always @* begin
        next_state = state;
        case (state)
            S_MEAS:  if (tmr == {TW{1'b0}}) next_state = S_CHECK;
            S_CHECK: next_state = (fill != 3'h0) ? S_CMD : S_MEAS;
            S_CMD: begin
                if (pop && (cbuf[rd_ptr] == CHAR_CR)) begin
                    next_state = S_RESP;
                end else if ((tmr == {TW{1'b0}}) && !pop) begin
                    // a character popped right at expiry wins, so valid and abort never coincide
                    next_state = S_MEAS;
                end
            end
            S_RESP:  if (i_rsp_valid && i_rsp_last && tx_ready) next_state = S_TCR;
            S_TCR:   if (tx_ready) next_state = S_TLF;
            S_TLF:   if (tx_ready) next_state = S_MEAS;
            default: next_state = S_MEAS;
        endcase
    end
    // state, timer and executor-side outputs
    always @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state        <= S_MEAS;
            tmr          <= MEAS_LAST;
            o_cmd_data   <= 8'h00;
            o_cmd_valid  <= 1'b0;
            o_cmd_exec   <= 1'b0;
            o_cmd_abort  <= 1'b0;
            o_meas_phase <= 1'b1;
        end else begin
            state        <= next_state;
            o_meas_phase <= (next_state == S_MEAS);
            o_cmd_valid  <= 1'b0;
            o_cmd_exec   <= 1'b0;
            o_cmd_abort  <= (state == S_CMD) && (next_state == S_MEAS);
            // timer reloads on entry to S_MEAS and S_CMD and on each pop in S_CMD, counts down to zero otherwise
            if ((next_state == S_MEAS) && (state != S_MEAS)) begin
                tmr <= MEAS_LAST;
            end else if ((next_state == S_CMD) && (state != S_CMD)) begin
                tmr <= TO_LAST;
            end else if (pop && (state == S_CMD)) begin
                // each character restarts the idle timeout
                tmr <= TO_LAST;
            end else if (tmr != {TW{1'b0}}) begin
                tmr <= tmr - {{(TW-1){1'b0}}, 1'b1};
            end
            if (pop) begin
                o_cmd_data <= cbuf[rd_ptr];
                // CR is the one terminator; it appears on o_cmd_data with exec, never with valid
                if (cbuf[rd_ptr] == CHAR_CR) begin
                    o_cmd_exec <= 1'b1;
                end else begin
                    o_cmd_valid <= 1'b1;
                end
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // response path: executor bytes, then CR and LF
    assign o_rsp_ready = (state == S_RESP) && tx_ready;
    always @* begin
        tx_valid = 1'b0;
        tx_data  = i_rsp_data;
        if (state == S_RESP) begin
            tx_valid = i_rsp_valid;
        end else if (state == S_TCR) begin
            tx_valid = 1'b1;
            tx_data  = CHAR_CR;
        end else if (state == S_TLF) begin
            tx_valid = 1'b1;
            tx_data  = CHAR_LF;
        end
    end

    aslk_uart_tx #(
        .BIT_CYCLES (BIT_CYCLES),
        .CW         (CW)
    ) u_tx (
        .i_sys_clk (i_sys_clk),
        .i_rst_b   (i_rst_b),
        .i_data    (tx_data),
        .i_valid   (tx_valid),
        .o_ready   (tx_ready),
        .o_txd     (o_txd)
    );

endmodule

// *** hw/aslk_uart_tx.v ***
`timescale 1ns/1ps
`include "aslk_consts.vh"

module aslk_uart_tx #(
    parameter BIT_CYCLES = `ASLK_BIT_CYCLES,
    parameter CW         = 11
) (
    // clock and reset
    input  wire       i_sys_clk,
    input  wire       i_rst_b,
    // byte handshake
    input  wire [7:0] i_data,
    input  wire       i_valid,
    output wire       o_ready,
    // serial line
    output reg        o_txd
);

    // bit time is cut to the counter width on purpose
    localparam integer  BIT_M1   = BIT_CYCLES - 1;
    localparam [CW-1:0] BIT_LAST = BIT_M1[CW-1:0];
    localparam [3:0]    LAST_IDX = `ASLK_STOP_IDX;

    reg [9:0]    shift;    // whole frame, lsb first, indexed by bit_idx
    reg [3:0]    bit_idx;  // bit being driven
    reg [CW-1:0] baud;     // cycles left in this bit
    reg          busy;     // a frame is on the line

    // ready only between frames, so a byte is never overwritten mid-frame
    assign o_ready = ~busy;

    ////////////////////////////////////////////////////////////////////////
    // frame shifter: start bit low, eight data lsb first, one stop high
    always @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            shift   <= 10'h3ff;
            bit_idx <= 4'h0;
            baud    <= {CW{1'b0}};
            busy    <= 1'b0;
            o_txd   <= 1'b1;
        end else if (!busy) begin
            if (i_valid) begin
                // load frame and drive start bit at once
                shift   <= {1'b1, i_data, 1'b0};
                o_txd   <= 1'b0;
                bit_idx <= 4'h0;
                baud    <= BIT_LAST;
                busy    <= 1'b1;
            end
        end else if (baud != {CW{1'b0}}) begin
            baud <= baud - {{(CW-1){1'b0}}, 1'b1};
        end else if (bit_idx == LAST_IDX) begin
            // stop bit served its full time; line idles high
            busy  <= 1'b0;
            o_txd <= 1'b1;
        end else begin
            bit_idx <= bit_idx + 4'h1;
            o_txd   <= shift[bit_idx + 4'h1];
            baud    <= BIT_LAST;
        end
    end

endmodule

// *** test/aslk_host_model.sv ***
`timescale 1ns/1ps
module aslk_host_model #(
    parameter int BIT = 16
) (
    // clock
    input  wire  i_sys_clk,
    // serial lines
    input  wire  i_line_in,
    output logic o_line_out
);
    logic [7:0] rx_q[$]; // bytes decoded from the device
    logic [7:0] d;       // frame being decoded
    initial o_line_out = 1'b1; // mark level while idle, no flow control lines
    ////////////////////////////////////////
    // one 8n1 frame lsb first; calls chain back to back with no gap
    task automatic send(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int k = 0; k < 10; k++) begin
            @(negedge i_sys_clk);
            o_line_out = f[k];
            repeat (BIT - 1) @(negedge i_sys_clk);
        end
    endtask
    ////////////////////////////////////////
    // receiver: mid-bit samples; a low stop bit drops the byte
    initial begin
        forever begin
            @(negedge i_line_in);
            repeat (BIT / 2) @(posedge i_sys_clk);
            if (i_line_in == 1'b0) begin
                for (int k = 0; k < 8; k++) begin
                    repeat (BIT) @(posedge i_sys_clk);
                    d[k] = i_line_in;
                end
                repeat (BIT) @(posedge i_sys_clk);
                if (i_line_in == 1'b1) rx_q.push_back(d);
            end
        end
    end
endmodule

// *** test/aslk_link_bench.sv ***
`timescale 1ns/1ps
module aslk_link_bench;
    localparam int BIT   = 16;   // shortened bit time
    localparam int MEAS  = 2000; // shortened measurement phase
    localparam int CTO   = 8000; // shortened command idle timeout
    localparam int PAUSE = 3000; // first-character pause, beyond MEAS
    // dut signals
    logic       i_sys_clk;
    logic       i_rst_b;
    wire        i_rxd;
    wire        o_txd;
    wire  [7:0] o_cmd_data;
    wire        o_cmd_valid;
    wire        o_cmd_exec;
    wire        o_cmd_abort;
    logic [7:0] i_rsp_data;
    logic       i_rsp_valid;
    logic       i_rsp_last;
    wire        o_rsp_ready;
    wire        o_meas_phase;
    // bookkeeping
    int         err_count, num_checks, n_exec, n_abort;
    logic [7:0] cmd_q[$], sent_q[$], rsp_q[$];

    aslk_link #(.BIT_CYCLES(BIT), .HALF_CYCLES(BIT / 2), .MEAS_CYCLES(MEAS), .CMD_TO(CTO)) aslk_link_i (
        .i_sys_clk, .i_rst_b, .i_rxd, .o_txd, .o_cmd_data, .o_cmd_valid, .o_cmd_exec, .o_cmd_abort,
        .i_rsp_data, .i_rsp_valid, .i_rsp_last, .o_rsp_ready, .o_meas_phase
    );
    aslk_host_model #(.BIT(BIT)) aslk_host_model_i (.i_sys_clk, .i_line_in(o_txd), .o_line_out(i_rxd));

    initial begin
        i_sys_clk = 1'b0;
        forever #2.5 i_sys_clk = ~i_sys_clk;
    end
    ////////////////////////////////////////
    // collect command events as the executor would see them
    always @(posedge i_sys_clk) begin
        if (o_cmd_valid === 1'b1) cmd_q.push_back(o_cmd_data);
        if (o_cmd_exec === 1'b1) n_exec++;
        if (o_cmd_abort === 1'b1) n_abort++;
    end
    ////////////////////////////////////////
    task automatic chk_byte(input string what, input logic [7:0] e, input logic [7:0] g);
        num_checks++;
        if (g !== e) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic chk_cnt(input string what, input int e, input int g);
        num_checks++;
        if (g != e) begin
            err_count++;
            $display("ERROR %s expected %0d seen %0d", what, e, g);
        end
    endtask
    task automatic cmp_q(input string what, ref logic [7:0] e[$], ref logic [7:0] g[$]);
        chk_cnt({what, " count"}, e.size(), g.size());
        for (int k = 0; k < e.size() && k < g.size(); k++) chk_byte(what, e[k], g[k]);
    endtask
    // executor: n random capitals, data held until taken
    task automatic reply(input int n);
        for (int k = 0; k < n; k++) begin
            @(negedge i_sys_clk);
            i_rsp_data = 8'h41 + 8'($urandom_range(25));
            i_rsp_valid = 1'b1;
            i_rsp_last = (k == n - 1);
            rsp_q.push_back(i_rsp_data);
            for (int t = 0; t < 400 && o_rsp_ready !== 1'b1; t++) @(negedge i_sys_clk);
            @(posedge i_sys_clk);
        end
        @(negedge i_sys_clk);
        i_rsp_valid = 1'b0;
        i_rsp_last = 1'b0;
    endtask
    // one exchange: first char, pause, rest (paced or not), cr, reply
    task automatic run_cmd(input int len, input bit paced, input int nrsp);
        logic [7:0] c;
        sent_q.delete();
        rsp_q.delete();
        cmd_q.delete();
        aslk_host_model_i.rx_q.delete();
        n_exec = 0;
        for (int k = 0; k < len; k++) begin
            c = 8'h61 + 8'($urandom_range(25));
            sent_q.push_back(c);
            aslk_host_model_i.send(c);
            if (k == 0 || paced) repeat (PAUSE) @(negedge i_sys_clk);
        end
        aslk_host_model_i.send(8'h0d);
        for (int t = 0; t < CTO && n_exec == 0; t++) @(negedge i_sys_clk);
        chk_cnt("exec pulses", 1, n_exec);
        chk_byte("meas phase in reply", 8'h00, {7'h00, o_meas_phase});
        cmp_q("command", sent_q, cmd_q);
        reply(nrsp);
        // give up after a bounded wait; the shortfall is flagged below
        for (int t = 0; t < 200 * nrsp + 600 && aslk_host_model_i.rx_q.size() < nrsp + 2; t++)
            @(negedge i_sys_clk);
        rsp_q.push_back(8'h0d);
        rsp_q.push_back(8'h0a);
        cmp_q("reply", rsp_q, aslk_host_model_i.rx_q);
        chk_byte("meas phase after reply", 8'h01, {7'h00, o_meas_phase});
    endtask
    // six chars while measuring, no cr: four kept, then idle abort
    task automatic overflow();
        cmd_q.delete();
        sent_q.delete();
        n_abort = 0;
        for (int k = 0; k < 6; k++) begin
            aslk_host_model_i.send(8'h30 + 8'(k));
            if (k < kept_chars(6)) sent_q.push_back(8'h30 + 8'(k));
        end
        for (int t = 0; t < MEAS + CTO + 500 && n_abort == 0; t++) @(negedge i_sys_clk);
        chk_cnt("abort pulses", 1, n_abort);
        cmp_q("buffered", sent_q, cmd_q);
    endtask
    // characters the measurement phase keeps out of n sent
    function automatic int kept_chars(input int n);
        return (n < 4) ? n : 4;
    endfunction
    task automatic final_report();
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    ////////////////////////////////////////
    initial begin
        i_rst_b = 1'b0;
        i_rsp_data = 8'h00;
        i_rsp_valid = 1'b0;
        i_rsp_last = 1'b0;
        void'($urandom(28865));
        repeat (12) @(negedge i_sys_clk);
        chk_byte("idle line", 8'h01, {7'h00, o_txd});
        i_rst_b = 1'b1;
        @(negedge i_sys_clk);
        chk_byte("meas phase after reset", 8'h01, {7'h00, o_meas_phase});
        run_cmd(1, 1'b0, 1);
        run_cmd(8, 1'b0, 2);
        overflow();
        repeat (3) run_cmd($urandom_range(4, 1), 1'($urandom_range(1)), $urandom_range(3, 1));
        final_report();
    end
    // hang guard, well beyond the expected run
    initial begin
        repeat (100000) @(posedge i_sys_clk);
        err_count++;
        final_report();
    end
endmodule

// *** test/aslk_link_monitor.sv ***
`timescale 1ns/1ps
module aslk_link_chk #(
    parameter int BIT_CYCLES = 16
) (
    // clock and reset
    input wire       i_sys_clk,
    input wire       i_rst_b,
    // link ports
    input wire       o_txd,
    input wire [7:0] o_cmd_data,
    input wire       o_cmd_valid,
    input wire       o_cmd_exec,
    input wire       o_cmd_abort,
    input wire       i_rsp_valid,
    input wire       i_rsp_last,
    input wire       o_rsp_ready,
    input wire       o_meas_phase
);
    // stop bit centre, counted from the accepting edge
    localparam int STOP_MID = BIT_CYCLES * 9 + BIT_CYCLES / 2 + 1;
    wire take = i_rsp_valid & o_rsp_ready; // reply byte accepted
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_b);
    ////////////////////////////////////////
    property p_exec_cr; o_cmd_exec |-> o_cmd_data == 8'h0d; endproperty
    a_exec_cr: assert property (p_exec_cr) else $error("exec without cr");
    property p_valid_no_cr; o_cmd_valid |-> o_cmd_data != 8'h0d; endproperty
    a_valid_no_cr: assert property (p_valid_no_cr) else $error("cr passed as char");
    // only one command event per cycle keeps the executor simple
    property p_one_event; $onehot0({o_cmd_valid, o_cmd_exec, o_cmd_abort}); endproperty
    a_one_event: assert property (p_one_event) else $error("command events overlap");
    property p_valid_meas; o_cmd_valid |-> !o_meas_phase; endproperty
    a_valid_meas: assert property (p_valid_meas) else $error("char out while measuring");
    property p_ready_meas; o_rsp_ready |-> !o_meas_phase; endproperty
    a_ready_meas: assert property (p_ready_meas) else $error("reply taken while measuring");
    property p_exec_ready; o_cmd_exec |-> ##[0:4] o_rsp_ready; endproperty
    a_exec_ready: assert property (p_exec_ready) else $error("no reply slot after exec");
    // start bit must stand a good part of a bit time
    property p_take_start; take |=> !o_txd [*8]; endproperty
    a_take_start: assert property (p_take_start) else $error("start bit missing");
    property p_take_stop; take |-> ##STOP_MID o_txd; endproperty
    a_take_stop: assert property (p_take_stop) else $error("stop bit low");
    property p_abort_meas; o_cmd_abort |-> ##[0:2] o_meas_phase; endproperty
    a_abort_meas: assert property (p_abort_meas) else $error("no return after abort");
    property p_meas_len; $rose(o_meas_phase) |=> o_meas_phase [*8]; endproperty
    a_meas_len: assert property (p_meas_len) else $error("measurement cut short");
    ////////////////////////////////////////
    c_exec: cover property (o_cmd_exec);
    c_abort: cover property (o_cmd_abort);
    c_last: cover property (take && i_rsp_last);
endmodule

bind aslk_link aslk_link_chk #(.BIT_CYCLES(BIT_CYCLES)) aslk_link_chk_i (
    .i_sys_clk, .i_rst_b, .o_txd, .o_cmd_data, .o_cmd_valid, .o_cmd_exec,
    .o_cmd_abort, .i_rsp_valid, .i_rsp_last, .o_rsp_ready, .o_meas_phase
);
